// ===== fcs_pkg.sv
// Constants, types and the command step record type for the flash command host.
// Assumes a byte-wide parallel flash with unlock-style command cycles.
package fcs_pkg;
    // Register word indices on the Avalon-MM slave.
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_WDATA = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    // Control field positions.
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_POLL_BIT = 4;
    // Status field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_EWIN = 3;
    localparam int ST_DATA_LSB = 8;
    // Status bit positions inside a byte read from the flash.
    localparam int POLARITY_POLL_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int TIMEOUT_FAILURE_BIT = 5;
    localparam int ERASE_WINDOW_BIT = 3;
    // Command bytes and unlock addresses.
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [16:0] ADDR_UNLOCK1 = 17'h00555;
    localparam logic [16:0] ADDR_UNLOCK2 = 17'h002aa;
    // Strobe timing: least low time of a strobe, and the input synchroniser depth.
    localparam int CLK_MHZ = 25;
    localparam int STROBE_LOW_NS = 100;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    // Host operations selected through the control register.
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET1 = 4'h1, OP_RESET3 = 4'h2, OP_AUTOSEL = 4'h3,
        OP_PROGRAM = 4'h4, OP_CHIP_ERASE = 4'h5, OP_SECTOR_ERASE = 4'h6,
        OP_SECTOR_ADD = 4'h7, OP_SUSPEND = 4'h8, OP_RESUME = 4'h9
    } fcs_op_type;
    // Address source of one bus cycle.
    typedef enum logic [1:0] {
        AS_UNLOCK1 = 2'h0, AS_UNLOCK2 = 2'h1, AS_USER = 2'h2, AS_ZERO = 2'h3
    } fcs_asrc_type;
    // One bus cycle of a command sequence.
    typedef struct packed {
        logic rd;
        logic last;
        fcs_asrc_type asrc;
        logic [7:0] data;
    } fcs_step_type;
endpackage

// ===== fcs_sync.sv
// Two-flop synchroniser for the flash data pins.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ns
module fcs_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Asynchronous input and its synchronised copy.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // Both stages in one state word; only stage two is read outside.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fcs_sync_state_type;

    fcs_sync_state_type r;
    fcs_sync_state_type r_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: the first stage feeds only the second.
    always_comb
    begin
        r_nxt = r;
        r_nxt.s1 = async_i;
        r_nxt.s2 = r.s1;
    end

    // Register the state.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign sync_o = r.s2;
endmodule

// ===== fcs_bus_cycle.sv
// Single flash bus cycle engine: one write or one read on the parallel pins.
// Assumes flash_dq_sync_i is already synchronised by the caller.
`timescale 1ns/1ns
module fcs_bus_cycle #(
    parameter int AW = 17
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Request from the sequencer.
    input wire logic start_i,
    input wire logic rd_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    // Flash pins.
    output logic [AW-1:0] flash_addr_o,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o,
    output logic flash_ce_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o,
    input wire logic [7:0] flash_dq_sync_i
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'h0, BC_SETUP = 2'h1, BC_LOW = 2'h2, BC_HOLD = 2'h3
    } fcs_bc_st_type;

    typedef struct packed {
        fcs_bc_st_type st;
        logic [3:0] cnt;
        logic rd;
        logic [AW-1:0] addr;
        logic [7:0] data;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic done;
    } fcs_bc_state_type;

    // Reads keep the strobe low for the synchroniser delay on top of the access time.
    localparam logic [3:0] WR_LOW = 4'(fcs_pkg::STROBE_LOW_CYC);
    localparam logic [3:0] RD_LOW = 4'(fcs_pkg::STROBE_LOW_CYC + fcs_pkg::SYNC_CYC);

    fcs_bc_state_type r;
    fcs_bc_state_type r_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencing: address set up with strobes high, strobes low, then
    // strobes high again with address and data held one more clock.
    always_comb
    begin
        r_nxt = r;
        r_nxt.done = 1'b0;
        case (r.st)
            BC_IDLE:
            begin
                if (start_i)
                begin
                    r_nxt.rd = rd_i;
                    r_nxt.addr = addr_i;
                    r_nxt.data = wdata_i;
                    r_nxt.dq_oe = !rd_i;
                    r_nxt.st = BC_SETUP;
                end
            end
            BC_SETUP:
            begin
                // Chip select and write strobe fall together, so the device
                // latches the already stable address.
                r_nxt.ce_n = 1'b0;
                r_nxt.we_n = r.rd;
                r_nxt.oe_n = !r.rd;
                r_nxt.cnt = r.rd ? RD_LOW : WR_LOW;
                r_nxt.st = BC_LOW;
            end
            BC_LOW:
            begin
                if (r.cnt == 4'h1)
                begin
                    // Strobes rise together while data still stands.
                    r_nxt.ce_n = 1'b1;
                    r_nxt.we_n = 1'b1;
                    r_nxt.oe_n = 1'b1;
                    if (r.rd)
                    begin
                        r_nxt.data = flash_dq_sync_i;
                    end
                    r_nxt.st = BC_HOLD;
                end
                else
                begin
                    r_nxt.cnt = r.cnt - 4'h1;
                end
            end
            BC_HOLD:
            begin
                r_nxt.dq_oe = 1'b0;
                r_nxt.done = 1'b1;
                r_nxt.st = BC_IDLE;
            end
            default:
            begin
                r_nxt.st = BC_IDLE;
            end
        endcase
    end

    // Register the state; strobes idle high.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            r <= '{st: BC_IDLE, cnt: 4'h0, rd: 1'b0, addr: '0, data: 8'h00, dq_oe: 1'b0,
                   ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, done: 1'b0};
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign done_o = r.done;
    assign rdata_o = r.data;
    assign flash_addr_o = r.addr;
    assign flash_dq_o = r.data;
    assign flash_dq_oe_o = r.dq_oe;
    assign flash_ce_n_o = r.ce_n;
    assign flash_we_n_o = r.we_n;
    assign flash_oe_n_o = r.oe_n;
endmodule

// ===== fcs_host.sv
// Host controller for a byte-wide command-driven flash, top level.
// Assumes software on Avalon-MM, flash pins asynchronous to clk_i.
//
// What this block does
// - Single F0 write returns to array read.
// - Autoselect: unlock, 90, then read ID.
// - Program: unlock, A0, then target byte.
// - Erase: six writes, 10 chip, 30 sector.
// - B0 suspends only a running sector erase.
// - Take valid data from a later read.
// - Recheck toggle after timeout bit sets.
`timescale 1ns/1ns
module fcs_host #(
    parameter int AW = 17
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Avalon-MM slave.
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Flash pins.
    output logic [AW-1:0] flash_addr_o,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [7:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_we_n_o,
    output logic flash_oe_n_o
);
    // Sequencer states.
    typedef enum logic [1:0] {
        S_IDLE = 2'h0, S_ISSUE = 2'h1, S_WAIT = 2'h2
    } fcs_st_type;

    // What the current bus cycle belongs to.
    typedef enum logic [1:0] {
        K_SEQ = 2'h0, K_POLL = 2'h1, K_FINAL = 2'h2, K_RESET = 2'h3
    } fcs_kind_type;

    typedef struct packed {
        fcs_st_type st;
        fcs_kind_type kind;
        fcs_pkg::fcs_op_type op;
        logic poll;
        logic [2:0] idx;
        logic [AW-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] prev;
        logic have_prev;
        logic recheck;
        logic busy;
        logic done;
        logic fail;
        logic ewin;
        logic [7:0] rdata;
        logic start;
        logic rd_ack;
        logic [31:0] rdat;
    } fcs_state_type;

    fcs_state_type r;
    fcs_state_type r_nxt;

    // Bus cycle engine hookup.
    logic cyc_rd;
    logic [AW-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    logic [7:0] dq_sync;
    fcs_pkg::fcs_step_type step;

    ////////////////////////////////////////////////////////////////////////////
    // Command step table: returns bus cycle idx of an operation.
    function automatic fcs_pkg::fcs_step_type step_of(input fcs_pkg::fcs_op_type op, input logic [2:0] idx);
        fcs_pkg::fcs_step_type s;
        logic [7:0] unl;
        s = '{rd: 1'b0, last: 1'b0, asrc: fcs_pkg::AS_UNLOCK1, data: fcs_pkg::CMD_UNLOCK1};
        // Shared unlock pattern: AA/555, 55/2AA, and for erase repeated at 3 and 4.
        unl = (idx[0] == 1'b0) ? fcs_pkg::CMD_UNLOCK1 : fcs_pkg::CMD_UNLOCK2;
        s.asrc = (idx[0] == 1'b0) ? fcs_pkg::AS_UNLOCK1 : fcs_pkg::AS_UNLOCK2;
        if (idx == 3'h3)
        begin
            s.asrc = fcs_pkg::AS_UNLOCK1;
            unl = fcs_pkg::CMD_UNLOCK1;
        end
        else if (idx == 3'h4)
        begin
            s.asrc = fcs_pkg::AS_UNLOCK2;
            unl = fcs_pkg::CMD_UNLOCK2;
        end
        s.data = unl;
        case (op)
            fcs_pkg::OP_READ:
            begin
                s = '{rd: 1'b1, last: 1'b1, asrc: fcs_pkg::AS_USER, data: 8'h00};
            end
            fcs_pkg::OP_RESET1:
            begin
                s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_ZERO, data: fcs_pkg::CMD_RESET};
            end
            fcs_pkg::OP_RESET3:
            begin
                if (idx == 3'h2)
                begin
                    s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_UNLOCK1, data: fcs_pkg::CMD_RESET};
                end
            end
            fcs_pkg::OP_AUTOSEL, fcs_pkg::OP_PROGRAM:
            begin
                if (idx == 3'h2)
                begin
                    s.asrc = fcs_pkg::AS_UNLOCK1;
                    s.data = (op == fcs_pkg::OP_AUTOSEL) ? fcs_pkg::CMD_AUTOSEL : fcs_pkg::CMD_PROGRAM;
                end
                else if (idx == 3'h3)
                begin
                    // ID or protection read, or the target byte write.
                    s = '{rd: (op == fcs_pkg::OP_AUTOSEL), last: 1'b1, asrc: fcs_pkg::AS_USER, data: r.wdata};
                end
            end
            fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECTOR_ERASE:
            begin
                if (idx == 3'h2)
                begin
                    s.asrc = fcs_pkg::AS_UNLOCK1;
                    s.data = fcs_pkg::CMD_ERASE_SETUP;
                end
                else if (idx == 3'h5)
                begin
                    // For sector erase the sector select bits come from the user address; chip erase writes to 555.
                    s.last = 1'b1;
                    s.asrc = (op == fcs_pkg::OP_CHIP_ERASE) ? fcs_pkg::AS_UNLOCK1 : fcs_pkg::AS_USER;
                    s.data = (op == fcs_pkg::OP_CHIP_ERASE) ? fcs_pkg::CMD_CHIP_ERASE : fcs_pkg::CMD_SECTOR_ERASE;
                end
            end
            fcs_pkg::OP_SECTOR_ADD:
            begin
                s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_USER, data: fcs_pkg::CMD_SECTOR_ERASE};
            end
            fcs_pkg::OP_SUSPEND:
            begin
                s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_ZERO, data: fcs_pkg::CMD_SUSPEND};
            end
            fcs_pkg::OP_RESUME:
            begin
                s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_ZERO, data: fcs_pkg::CMD_RESUME};
            end
            default:
            begin
                s = '{rd: 1'b0, last: 1'b1, asrc: fcs_pkg::AS_ZERO, data: fcs_pkg::CMD_RESET};
            end
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Parameters of the next bus cycle, chosen by what it belongs to.
    always_comb
    begin
        step = step_of(r.op, r.idx);
        cyc_rd = 1'b1;
        cyc_addr = r.addr;
        cyc_data = fcs_pkg::CMD_RESET;
        case (r.kind)
            K_SEQ:
            begin
                cyc_rd = step.rd;
                cyc_data = step.data;
                case (step.asrc)
                    fcs_pkg::AS_UNLOCK1: cyc_addr = AW'(fcs_pkg::ADDR_UNLOCK1);
                    fcs_pkg::AS_UNLOCK2: cyc_addr = AW'(fcs_pkg::ADDR_UNLOCK2);
                    fcs_pkg::AS_USER: cyc_addr = r.addr;
                    default: cyc_addr = '0;
                endcase
            end
            K_RESET:
            begin
                // Abandon a failed operation with the single-cycle reset.
                cyc_rd = 1'b0;
                cyc_addr = '0;
            end
            default:
            begin
                cyc_rd = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register slave and sequencer next state.
    always_comb
    begin
        r_nxt = r;
        r_nxt.start = 1'b0;
        r_nxt.rd_ack = avs_read_i && !r.rd_ack;
        // Read data is registered, so reads answer one clock late.
        case (avs_address_i)
            fcs_pkg::REG_CTRL: r_nxt.rdat = {27'h0, r.poll, r.op};
            fcs_pkg::REG_ADDR: r_nxt.rdat = 32'(r.addr);
            fcs_pkg::REG_WDATA: r_nxt.rdat = {24'h0, r.wdata};
            fcs_pkg::REG_STATUS: r_nxt.rdat = {16'h0, r.rdata, 4'h0, r.ewin, r.fail, r.done, r.busy};
            default: r_nxt.rdat = 32'h0;
        endcase
        // Address and data registers are only written while idle.
        if (avs_write_i && !r.busy)
        begin
            case (avs_address_i)
                fcs_pkg::REG_CTRL:
                begin
                    r_nxt.op = fcs_pkg::fcs_op_type'(avs_writedata_i[fcs_pkg::CTRL_OP_LSB +: 4]);
                    r_nxt.poll = avs_writedata_i[fcs_pkg::CTRL_POLL_BIT];
                    r_nxt.idx = 3'h0;
                    r_nxt.kind = K_SEQ;
                    r_nxt.busy = 1'b1;
                    r_nxt.done = 1'b0;
                    r_nxt.fail = 1'b0;
                    r_nxt.st = S_ISSUE;
                end
                fcs_pkg::REG_ADDR: r_nxt.addr = avs_writedata_i[AW-1:0];
                fcs_pkg::REG_WDATA: r_nxt.wdata = avs_writedata_i[7:0];
                default: r_nxt.busy = r.busy;
            endcase
        end
        case (r.st)
            S_IDLE:
            begin
                r_nxt.busy = r_nxt.busy;
            end
            S_ISSUE:
            begin
                r_nxt.start = 1'b1;
                r_nxt.st = S_WAIT;
            end
            S_WAIT:
            begin
                if (cyc_done)
                begin
                    r_nxt.st = S_ISSUE;
                    case (r.kind)
                        K_SEQ:
                        begin
                            if (!step.last)
                            begin
                                r_nxt.idx = r.idx + 3'h1;
                            end
                            else if (r.poll && !step.rd)
                            begin
                                // Status is valid once the last write strobe rose.
                                r_nxt.kind = K_POLL;
                                r_nxt.have_prev = 1'b0;
                                r_nxt.recheck = 1'b0;
                            end
                            else
                            begin
                                r_nxt.rdata = step.rd ? cyc_rdata : r.rdata;
                                r_nxt.busy = 1'b0;
                                r_nxt.done = 1'b1;
                                r_nxt.st = S_IDLE;
                            end
                        end
                        K_POLL:
                        begin
                            r_nxt.prev = cyc_rdata;
                            r_nxt.have_prev = 1'b1;
                            r_nxt.ewin = cyc_rdata[fcs_pkg::ERASE_WINDOW_BIT];
                            if (r.have_prev && (cyc_rdata[fcs_pkg::TOGGLE_STATUS_BIT] == r.prev[fcs_pkg::TOGGLE_STATUS_BIT]))
                            begin
                                // Toggling stopped; fetch the byte on a later read.
                                r_nxt.kind = K_FINAL;
                            end
                            else if (r.have_prev && cyc_rdata[fcs_pkg::TIMEOUT_FAILURE_BIT])
                            begin
                                // One more pair before declaring failure.
                                if (r.recheck)
                                begin
                                    r_nxt.fail = 1'b1;
                                    r_nxt.kind = K_RESET;
                                end
                                r_nxt.recheck = 1'b1;
                            end
                        end
                        K_FINAL:
                        begin
                            r_nxt.rdata = cyc_rdata;
                            r_nxt.busy = 1'b0;
                            r_nxt.done = 1'b1;
                            r_nxt.st = S_IDLE;
                        end
                        default:
                        begin
                            r_nxt.busy = 1'b0;
                            r_nxt.done = 1'b1;
                            r_nxt.st = S_IDLE;
                        end
                    endcase
                end
            end
            default:
            begin
                r_nxt.st = S_IDLE;
            end
        endcase
    end

    // Register the state.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    // Reads wait one clock; any write while busy stalls until idle.
    assign avs_waitrequest_o = (avs_read_i && !r.rd_ack) || (avs_write_i && r.busy);
    assign avs_readdata_o = r.rdat;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser and bus cycle engine.
    fcs_sync #(.W(8)) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i(flash_dq_i),
        .sync_o(dq_sync)
    );

    fcs_bus_cycle #(.AW(AW)) u_cyc (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .start_i(r.start),
        .rd_i(cyc_rd),
        .addr_i(cyc_addr),
        .wdata_i(cyc_data),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .flash_addr_o(flash_addr_o),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe_o(flash_dq_oe_o),
        .flash_ce_n_o(flash_ce_n_o),
        .flash_we_n_o(flash_we_n_o),
        .flash_oe_n_o(flash_oe_n_o),
        .flash_dq_sync_i(dq_sync)
    );
endmodule

// ===== fcs_chk.sv
// Checker of the host's flash strobes and its Avalon read handshake.
// Assumes it is bound into fcs_host and sees that module's ports only.
`timescale 1ns/1ns
module fcs_chk #(
    parameter int AW = 17
) (
    // Clock, reset and bus handshake.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic avs_read_i,
    input wire logic avs_waitrequest_o,
    // Flash pins.
    input wire logic [AW-1:0] flash_addr_o,
    input wire logic flash_dq_oe_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_we_width: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*3] ##1 flash_we_n_o) else $error("we width");
    a_oe_width: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*5] ##1 flash_oe_n_o) else $error("oe width");
    a_we_frame: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o) else $error("we frame");
    a_addr_hold: assert property (!flash_we_n_o || !flash_oe_n_o |-> $stable(flash_addr_o)) else $error("addr moved");
    a_rd_float: assert property (!flash_oe_n_o |-> !flash_ce_n_o && !flash_dq_oe_o) else $error("read frame");
    a_ce_rise: assert property ($rose(flash_we_n_o) |-> flash_ce_n_o) else $error("ce held");
    a_ce_gap: assert property ($rose(flash_ce_n_o) |-> flash_ce_n_o [*2]) else $error("ce gap");
    a_rd_ack: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("ack");
endmodule
bind fcs_host fcs_chk #(.AW(AW)) u_chk (.clk_i, .resetn_i, .avs_read_i, .avs_waitrequest_o,
    .flash_addr_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o);

// ===== fcs_flash_model.sv
// Behavioural flash answering command writes and status reads.
// Assumes the bench resolves the data pins; sector 7 is protected.
`timescale 1ns/1ns
module fcs_flash_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value.
    parameter logic [7:0] PART = 8'hc5 // Arbitrary value.
) (
    // Flash pins seen from the device.
    input wire logic [16:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [0:131071];
    logic [16:0] la;
    logic [7:0] pd = 8'h00;
    logic asel = 1'b0, tog = 1'b0, ers = 1'b0, tmo = 1'b0;
    int st = 0, busy = 0;
    wire wr_n = ce_n_i | we_n_i;
    wire rd_n = ce_n_i | oe_n_i;
    initial
        foreach (mem[i]) mem[i] = 8'hff;
    // Address when the later strobe falls, data when the first one rises.
    always @(negedge wr_n) la = addr_i;
    always @(posedge wr_n)
        if (busy == 0 || tmo)
        begin
            busy = dq_i == 8'hf0 ? 0 : busy;
            asel = (asel | (st == 2 && la == 17'h555 && dq_i == 8'h90)) & (dq_i != 8'hf0);
            case (st)
                0, 3: st = (la == 17'h555 && dq_i == 8'haa) ? st + 1 : 0;
                1, 4: st = (la == 17'h2aa && dq_i == 8'h55) ? st + 1 : 0;
                2: st = la != 17'h555 ? 0 : dq_i == 8'ha0 ? 6 : dq_i == 8'h80 ? 3 : 0;
                5, 6:
                begin
                    ers = st == 5;
                    tmo = !ers && |(dq_i & ~mem[la]);
                    pd = dq_i;
                    busy = 4;
                    foreach (mem[i])
                        if (i[16:14] != 3'h7 && (ers ? dq_i == 8'h10 || i[16:14] == la[16:14] : i == la))
                            mem[i] = ers ? 8'hff : mem[i] & dq_i;
                    st = 0;
                end
                default: st = 0;
            endcase
        end
    // Status while busy, codes in autoselect, array data otherwise.
    always @(negedge rd_n)
        if (busy > 0)
        begin
            busy = tmo ? busy : busy - 1;
            tog = !tog;
            dq_o = {ers ? 1'b0 : !pd[7], tog, tmo, 1'h0, ers, 3'h0};
        end
        else if (asel)
            dq_o = addr_i[1] ? {7'h0, addr_i[16:14] == 3'h7} : addr_i[0] ? PART : MAKER;
        else
            dq_o = mem[addr_i];
    // A released bus shows the inverse, so no stale value can pass.
    always @(posedge rd_n) dq_o = ~dq_o;
endmodule

// ===== fcs_tb.sv
// Bench driving the host over Avalon-MM against the flash model.
// Assumes the package, design, model and checker compile first.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t %h", $time, a); end end
module testbench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] avs_address_i = 3'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, s;
    logic avs_waitrequest_o, oe, ce_n, we_n, oe_n;
    logic [16:0] fa;
    logic [7:0] hq, mq;
    wire [7:0] dq = oe ? hq : mq;
    int err_total = 0;
    int n_tests = 0;
    always #20 clk_i = !clk_i;
    fcs_host u_fcs_host (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .flash_addr_o(fa), .flash_dq_o(hq), .flash_dq_oe_o(oe),
        .flash_dq_i(dq), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
    fcs_flash_model u_fcs_flash_model (.addr_i(fa), .dq_i(dq), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(mq));
    task automatic finish_test;
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One Avalon transfer, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        s = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // Starts one host operation and polls status until busy clears.
    task automatic op(input logic [3:0] o, input logic [16:0] a, input logic [7:0] d = 8'h00);
        bus(1'b1, fcs_pkg::REG_ADDR, {15'h0, a});
        bus(1'b1, fcs_pkg::REG_WDATA, {24'h0, d});
        bus(1'b1, fcs_pkg::REG_CTRL, {27'h0, o inside {4'h4, 4'h5, 4'h6}, o});
        do bus(1'b0, fcs_pkg::REG_STATUS, 32'h0); while (s[fcs_pkg::ST_BUSY] !== 1'b0);
    endtask
    task automatic t_read;
        op(4'h0, 17'h00123);
        `CHK(s[15:8], 8'h3a)
        bus(1'b0, 3'h5, 32'h0);
        `CHK(s, 32'h0)
        for (int o = 7; o < 10; o++)
        begin
            op(4'(o), 17'h0);
            op(4'h0, 17'h00123);
            `CHK(s[15:8], 8'h3a)
        end
    endtask
    task automatic t_asel;
        logic [16:0] a [4] = '{17'h0, 17'h1, 17'h1c002, 17'h2};
        logic [7:0] e [4] = '{8'h3c, 8'hc5, 8'h01, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            op(4'h3, a[i]);
            `CHK(s[15:8], e[i])
            op(i[0] ? 4'h2 : 4'h1, 17'h0);
            op(4'h0, 17'h00123);
            `CHK(s[15:8], 8'h3a)
        end
    endtask
    task automatic t_prog;
        op(4'h4, 17'h01234, 8'h5a);
        `CHK(s[15:8], 8'h5a)
        `CHK(s[2:1], 2'h1)
        op(4'h4, 17'h01234, 8'hff);
        `CHK(s[2:1], 2'h3)
        op(4'h4, 17'h1c010, 8'h00);
        `CHK(s[15:8], 8'h0f)
    endtask
    task automatic t_erase;
        op(4'h6, 17'h04000);
        `CHK(s[15:8], 8'hff)
        `CHK(u_fcs_flash_model.mem[17'h01234], 8'h5a)
        op(4'h5, 17'h01234);
        `CHK(u_fcs_flash_model.mem[17'h01234], 8'hff)
        `CHK(u_fcs_flash_model.mem[17'h1c010], 8'h0f)
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        u_fcs_flash_model.mem[17'h00123] = 8'h3a;
        u_fcs_flash_model.mem[17'h04000] = 8'h11;
        u_fcs_flash_model.mem[17'h1c010] = 8'h0f;
        t_read;
        t_asel;
        t_prog;
        t_erase;
        finish_test;
    end
    initial
    begin
        #2000000;
        err_total++;
        finish_test;
    end
endmodule
